//--- verilog/cgrf_consts.vh
// Constants for the general register file: operations, sizes, select fields, states
`ifndef CGRF_CONSTS_VH
`define CGRF_CONSTS_VH

// ****************************************************************
// Operand sizes
// ****************************************************************
`define CGRF_SZ_BYTE   2'h0
`define CGRF_SZ_WORD   2'h1
`define CGRF_SZ_LONG   2'h2

// ****************************************************************
// Operation codes
// ****************************************************************
`define CGRF_OP_NOP    4'h0
`define CGRF_OP_MOVE   4'h1
`define CGRF_OP_AND    4'h2
`define CGRF_OP_OR     4'h3
`define CGRF_OP_XOR    4'h4
`define CGRF_OP_NOT    4'h5
`define CGRF_OP_BITSET 4'h6
`define CGRF_OP_BITCLR 4'h7
`define CGRF_OP_BINV   4'h8
`define CGRF_OP_BSTO   4'h9
`define CGRF_OP_BISTO  4'hA
`define CGRF_OP_MSTORE 4'hB
`define CGRF_OP_MLOAD  4'hC

// ****************************************************************
// Field positions of a register select
// ****************************************************************
`define CGRF_SEL_HALF  3
`define CGRF_SEL_IDX_H 2

// ****************************************************************
// Reset values, stack register, multi-transfer states
// ****************************************************************
`define CGRF_GPR_RST   32'h00000000
`define CGRF_SP_IDX    3'h7
`define CGRF_ST_IDLE   1'h0
`define CGRF_ST_XFER   1'h1

`endif

//--- verilog/cgrf_logic_unit.v
// Logic and bit-manipulation datapath of the general register file
`timescale 1ns/10ps
`include "cgrf_consts.vh"

module cgrf_logic_unit (
  // Operation
  input  wire [3:0]  op,
  // Word operands
  input  wire [31:0] opa,
  input  wire [31:0] opb,
  // Bit operand
  input  wire [7:0]  bit_byte,
  input  wire [2:0]  bit_num,
  input  wire        bit_carry,
  // Results
  output reg  [31:0] word_res,
  output reg  [7:0]  byte_res
);

  // ****************************************************************
  // Combinational results
  // ****************************************************************
  reg [7:0] mask;

  // Bitwise ops on the full word; the caller keeps only the sized lanes
  always @* begin
    mask = 8'h01 << bit_num;
    case (op)
      `CGRF_OP_AND: word_res = opa & opb;       // [RULE_07]
      `CGRF_OP_OR:  word_res = opa | opb;       // [RULE_08]
      `CGRF_OP_XOR: word_res = opa ^ opb;       // [RULE_09]
      `CGRF_OP_NOT: word_res = ~opa;            // [RULE_10]
      default:      word_res = opb;
    endcase
    // Whole byte in, one bit changed, whole byte out
    case (op)
      `CGRF_OP_BITSET: byte_res = bit_byte | mask;                      // [RULE_14]
      `CGRF_OP_BITCLR: byte_res = bit_byte & ~mask;                     // [RULE_14] [RULE_15]
      `CGRF_OP_BINV:  byte_res = bit_byte ^ mask;                       // [RULE_14]
      `CGRF_OP_BSTO:  byte_res = bit_carry ? (bit_byte | mask) : (bit_byte & ~mask);
      `CGRF_OP_BISTO: byte_res = bit_carry ? (bit_byte & ~mask) : (bit_byte | mask);
      default:        byte_res = bit_byte;
    endcase
  end

endmodule

//--- verilog/cgrf_regfile.v
// General register file of the core: eight 32-bit registers with logic datapath
//
// Operation
// RULE_01: Eight alike 32-bit registers serve as address or data registers.
// RULE_02: Data operands are read and written as 32, 16 or 8 bits.
// RULE_03: Each register splits into equal upper and lower 16-bit halves.
// RULE_04: Each lower half splits into equal high and low bytes.
// RULE_05: Width and role are chosen per instruction and per register.
// RULE_06: Register 7 is also the stack pointer for exceptions, calls and returns.
// RULE_07: AND of destination with register or immediate is written back.
// RULE_08: Inclusive OR of destination with register or immediate is written back.
// RULE_09: Exclusive OR of destination with register or immediate is written back.
// RULE_10: One's complement of a register is written back at any size.
// RULE_11: Test-and-set names only registers 0, 1, 4 or 5. No test-and-set operation is implemented.
// RULE_12: Multiple store and load never carry register 7.
// RULE_13: Multiple transfers use only groups 0-1, 2-3, 4-5, 0-2, 4-6 and 0-3.
// RULE_14: Bit ops read the whole byte, change one bit and write the byte back.
// RULE_15: Bit clear can clear an I/O flag without a prior read.
// RULE_16: Byte and word writes change only the addressed lanes.
// RULE_17: Upper halves also form the top of 32-bit data and address values.
`timescale 1ns/10ps
`include "cgrf_consts.vh"

module cgrf_regfile (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Instruction from decode
  input  wire        op_valid,
  input  wire [3:0]  op_code,
  input  wire [1:0]  op_size,
  input  wire [3:0]  dst_sel,
  input  wire [3:0]  src_sel,
  input  wire        use_imm,
  input  wire [31:0] imm,
  // Bit manipulation
  input  wire [2:0]  bit_num,
  input  wire        bit_carry,
  input  wire        bit_to_io,
  input  wire [7:0]  io_rdata,
  // Multiple transfer
  input  wire [2:0]  multi_first,
  input  wire [2:0]  multi_cnt,
  input  wire [31:0] xfer_in,
  // Implicit stack pointer update
  input  wire        sp_load,
  input  wire [31:0] sp_data,
  // Read port
  input  wire [3:0]  rd_sel,
  input  wire [1:0]  rd_size,
  // Outputs
  output reg  [31:0] rd_data_r,
  output reg  [31:0] sp_r,
  output reg  [31:0] result_r,
  output reg  [7:0]  io_wdata_r,
  output reg         io_we_r,
  output reg  [31:0] xfer_data_r,
  output reg  [2:0]  xfer_idx_r,
  output reg         xfer_valid_r,
  output reg         xfer_load_r,
  output reg         busy_r,
  output reg         err_r
);

  // ****************************************************************
  // Lane helpers
  // ****************************************************************
  // Zero-extended view of the selected portion
  function [31:0] pick;
    input [31:0] v;
    input [1:0]  sz;
    input        hi;
    begin
      case (sz)
        `CGRF_SZ_BYTE: pick = hi ? {24'h000000, v[15:8]} : {24'h000000, v[7:0]}; // [RULE_04]
        `CGRF_SZ_WORD: pick = hi ? {16'h0000, v[31:16]} : {16'h0000, v[15:0]};   // [RULE_03]
        default:       pick = v;                                                 // [RULE_17]
      endcase
    end
  endfunction

  // Merge new data into the addressed lanes only
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nv;
    input [1:0]  sz;
    input        hi;
    begin
      case (sz)
        `CGRF_SZ_BYTE: merge = hi ? {old[31:16], nv[7:0], old[7:0]}
                                  : {old[31:8], nv[7:0]};        // [RULE_16]
        `CGRF_SZ_WORD: merge = hi ? {nv[15:0], old[15:0]}
                                  : {old[31:16], nv[15:0]};      // [RULE_16]
        default:       merge = nv;
      endcase
    end
  endfunction

  // ****************************************************************
  // Register storage
  // ****************************************************************
  wire [31:0] gpr_w [0:7];
  reg         wr_en;
  reg  [2:0]  wr_idx;
  reg  [31:0] wr_val;
  reg         state_r;
  reg  [2:0]  idx_r;
  reg  [2:0]  left_r;

  // Eight identical registers; the stack pointer load beats an instruction write
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_gpr
      reg [31:0] q_r;
      assign gpr_w[gi] = q_r;
      always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          q_r <= `CGRF_GPR_RST;
        end else if (sp_load && (gi == 7)) begin
          q_r <= sp_data;                                  // [RULE_06]
        end else if (wr_en && (wr_idx == gi)) begin
          q_r <= wr_val;                                   // [RULE_01]
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Operand fetch and datapath
  // ****************************************************************
  wire [2:0]  dst_idx = dst_sel[`CGRF_SEL_IDX_H:0];
  wire        dst_hi  = dst_sel[`CGRF_SEL_HALF];
  wire [2:0]  src_idx = src_sel[`CGRF_SEL_IDX_H:0];
  wire        src_hi  = src_sel[`CGRF_SEL_HALF];
  wire [31:0] dst_full = gpr_w[dst_idx];
  wire        is_bit  = (op_code >= `CGRF_OP_BITSET) && (op_code <= `CGRF_OP_BISTO);
  wire        is_multi = (op_code == `CGRF_OP_MSTORE) || (op_code == `CGRF_OP_MLOAD);
  // Each instruction carries its own size and selects
  wire [31:0] opa = pick(dst_full, op_size, dst_hi);                       // [RULE_05]
  wire [31:0] opb = use_imm ? imm : pick(gpr_w[src_idx], op_size, src_hi); // [RULE_02]
  wire [7:0]  reg_byte = dst_hi ? dst_full[15:8] : dst_full[7:0];
  wire [7:0]  bit_byte = bit_to_io ? io_rdata : reg_byte;
  wire [31:0] word_res;
  wire [7:0]  byte_res;

  cgrf_logic_unit u_logic (
    .op        (op_code),
    .opa       (opa),
    .opb       (opb),
    .bit_byte  (bit_byte),
    .bit_num   (bit_num),
    .bit_carry (bit_carry),
    .word_res  (word_res),
    .byte_res  (byte_res)
  );

  // Only the six documented groups, never holding the stack register
  wire group_ok = ((multi_cnt == 3'h2) && ((multi_first == 3'h0) ||
                   (multi_first == 3'h2) || (multi_first == 3'h4))) ||
                  ((multi_cnt == 3'h3) && ((multi_first == 3'h0) ||
                   (multi_first == 3'h4))) ||
                  ((multi_cnt == 3'h4) && (multi_first == 3'h0));      // [RULE_12] [RULE_13]

  wire accept = op_valid && (state_r == `CGRF_ST_IDLE);

  // ****************************************************************
  // Single write port selection
  // ****************************************************************
  // Multiple loads hold off instructions, so one port is enough
  always @* begin
    wr_en  = 1'b0;
    wr_idx = dst_idx;
    wr_val = dst_full;
    if (state_r == `CGRF_ST_XFER) begin
      wr_en  = xfer_load_r;
      wr_idx = idx_r;
      wr_val = xfer_in;
    end else if (accept && is_bit && !bit_to_io) begin
      wr_en  = 1'b1;
      wr_val = merge(dst_full, {24'h000000, byte_res}, `CGRF_SZ_BYTE, dst_hi); // [RULE_14]
    end else if (accept && (op_code >= `CGRF_OP_MOVE) && (op_code <= `CGRF_OP_NOT)) begin
      wr_en  = 1'b1;
      wr_val = merge(dst_full, word_res, op_size, dst_hi);   // [RULE_07] [RULE_08] [RULE_09]
    end
  end

  // ****************************************************************
  // Multiple transfer sequencer and status outputs
  // ****************************************************************
  // One register per cycle, lowest index first
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r      <= `CGRF_ST_IDLE;
      idx_r        <= 3'h0;
      left_r       <= 3'h0;
      xfer_data_r  <= 32'h00000000;
      xfer_idx_r   <= 3'h0;
      xfer_valid_r <= 1'b0;
      xfer_load_r  <= 1'b0;
      busy_r       <= 1'b0;
      err_r        <= 1'b0;
    end else begin
      err_r <= 1'b0;
      case (state_r)
        `CGRF_ST_IDLE: begin
          if (accept && is_multi) begin
            if (group_ok) begin
              state_r      <= `CGRF_ST_XFER;
              idx_r        <= multi_first;
              left_r       <= multi_cnt - 3'h1;
              xfer_idx_r   <= multi_first;
              xfer_data_r  <= gpr_w[multi_first];
              xfer_valid_r <= 1'b1;
              xfer_load_r  <= (op_code == `CGRF_OP_MLOAD);
              busy_r       <= 1'b1;
            end else begin
              err_r <= 1'b1;                               // [RULE_13]
            end
          end
        end
        `CGRF_ST_XFER: begin
          // left_r counts the beats still to come after the one now shown
          if (left_r == 3'h0) begin
            state_r      <= `CGRF_ST_IDLE;
            xfer_valid_r <= 1'b0;
            busy_r       <= 1'b0;
          end else begin
            idx_r        <= idx_r + 3'h1;
            left_r       <= left_r - 3'h1;
            xfer_idx_r   <= idx_r + 3'h1;
            xfer_data_r  <= gpr_w[idx_r + 3'h1];
          end
        end
        default: begin
          state_r <= `CGRF_ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Read port, stack mirror, result and I/O byte write
  // ****************************************************************
  // Registered views keep every output on a flip-flop
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r  <= 32'h00000000;
      sp_r       <= `CGRF_GPR_RST;
      result_r   <= 32'h00000000;
      io_wdata_r <= 8'h00;
      io_we_r    <= 1'b0;
    end else begin
      rd_data_r <= pick(gpr_w[rd_sel[`CGRF_SEL_IDX_H:0]], rd_size, rd_sel[`CGRF_SEL_HALF]);
      sp_r      <= sp_load ? sp_data : (wr_en && (wr_idx == `CGRF_SP_IDX)) ? wr_val
                                     : gpr_w[`CGRF_SP_IDX];  // [RULE_06]
      io_we_r   <= accept && is_bit && bit_to_io;
      if (accept && is_bit) begin
        result_r <= {24'h000000, byte_res};
      end else if (accept && !is_multi && (op_code != `CGRF_OP_NOP)) begin
        result_r <= pick(word_res, op_size, 1'b0);
      end
      // Flag clear writes the byte back straight away, no prior read cycle
      if (accept && is_bit && bit_to_io) begin
        io_wdata_r <= byte_res;                            // [RULE_15]
      end
    end
  end

endmodule

//--- tb/cgrf_regfile_asserts.sv
// Port checker of the general register file
`timescale 1ns/10ps
`include "cgrf_consts.vh"
module cgrf_asserts (
  // Clock, reset and requests
  input wire        clk, rst_n, op_valid, bit_to_io, sp_load,
  input wire [3:0]  op_code,
  input wire [2:0]  bit_num, multi_first, multi_cnt,
  input wire [7:0]  io_rdata,
  input wire [31:0] sp_data,
  // Outputs
  input wire        io_we_r, xfer_valid_r, busy_r, err_r,
  input wire [7:0]  io_wdata_r,
  input wire [31:0] sp_r,
  input wire [2:0]  xfer_idx_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Accepted transfer and its group; only six groups are allowed, none holding the stack register
  wire take_m = op_valid && !busy_r &&
    (op_code == `CGRF_OP_MSTORE || op_code == `CGRF_OP_MLOAD);
  wire [5:0] grp = {multi_first, multi_cnt};
  wire grp_ok = grp == 6'h02 || grp == 6'h12 || grp == 6'h22 ||
    grp == 6'h03 || grp == 6'h23 || grp == 6'h04;
  wire io_bit = op_valid && !busy_r && bit_to_io &&
    op_code >= `CGRF_OP_BITSET && op_code <= `CGRF_OP_BISTO;
  sequence s_step; xfer_valid_r ##1 xfer_valid_r; endsequence
  sequence s_io_clr; io_bit && op_code == `CGRF_OP_BITCLR; endsequence
  // ********
  // Port relations
  // ********
  group_bad_a: assert property (take_m && !grp_ok |=> err_r && !busy_r)
    else $error("illegal group not refused");
  err_cause_a: assert property (err_r |-> $past(take_m && !grp_ok))
    else $error("error pulse without cause");
  group_start_a: assert property (take_m && grp_ok |=>
    xfer_valid_r && xfer_idx_r == $past(multi_first)) else $error("transfer start wrong");
  two_beats_a: assert property (take_m && grp_ok && multi_cnt == 3'h2 |=>
    busy_r [*2] ##1 !busy_r) else $error("two beat length wrong");
  four_beats_a: assert property (take_m && grp_ok && multi_cnt == 3'h4 |=>
    busy_r [*4] ##1 !busy_r) else $error("four beat length wrong");
  idx_step_a: assert property (s_step |-> xfer_idx_r == $past(xfer_idx_r) + 3'h1)
    else $error("index not stepping");
  no_sp_xfer_a: assert property (xfer_valid_r |-> xfer_idx_r != `CGRF_SP_IDX)
    else $error("stack register transferred");
  io_clear_a: assert property (s_io_clr |=> io_we_r &&
    io_wdata_r == ($past(io_rdata) & ~(8'h01 << $past(bit_num)))) else $error("io clear wrong");
  io_cause_a: assert property (io_we_r |-> $past(io_bit))
    else $error("io write without bit op");
  sp_follow_a: assert property (sp_load |=> sp_r == $past(sp_data))
    else $error("stack load lost");
endmodule
bind cgrf_regfile cgrf_asserts cgrf_asserts_inst (.clk(clk), .rst_n(rst_n),
  .op_valid(op_valid), .bit_to_io(bit_to_io), .sp_load(sp_load), .op_code(op_code),
  .bit_num(bit_num), .multi_first(multi_first), .multi_cnt(multi_cnt),
  .io_rdata(io_rdata), .sp_data(sp_data), .io_we_r(io_we_r), .xfer_valid_r(xfer_valid_r),
  .busy_r(busy_r), .err_r(err_r), .io_wdata_r(io_wdata_r), .sp_r(sp_r),
  .xfer_idx_r(xfer_idx_r));

//--- tb/cgrf_core_model.sv
// Core-side model that feeds load data during multi transfers
`timescale 1ns/10ps
module cgrf_core_model (
  // Clock
  input  wire        clk,
  // Transfer status
  input  wire        xfer_valid_r,
  input  wire        xfer_load_r,
  input  wire [2:0]  xfer_idx_r,
  // Load data
  output wire [31:0] xfer_in
);
  reg [31:0] noise_r = 32'h00000001;
  // Churn outside load beats so stale data is never taken for good
  always @(posedge clk) begin
    noise_r <= {noise_r[30:0], ~noise_r[31]} ^ 32'h9E3779B9;
  end
  // Answers only for the register the core names
  assign xfer_in = (xfer_valid_r && xfer_load_r) ?
    32'hA5C30000 + 32'h00010101 * xfer_idx_r : noise_r;
endmodule

//--- tb/cgrf_regfile_tb.sv
// Self-checking bench of the general register file
`timescale 1ns/10ps
`include "cgrf_consts.vh"
module cgrf_regfile_tb;
  reg         clk, rst_n, op_valid, use_imm, bit_carry, bit_to_io, sp_load;
  reg  [3:0]  op_code, dst_sel, src_sel, rd_sel;
  reg  [1:0]  op_size, rd_size;
  reg  [2:0]  bit_num, multi_first, multi_cnt;
  reg  [31:0] imm, sp_data, exp_res;
  reg  [7:0]  io_rdata;
  reg  [31:0] gpr [0:7];
  wire [31:0] xfer_in, rd_data_r, sp_r, result_r, xfer_data_r;
  wire [7:0]  io_wdata_r;
  wire [2:0]  xfer_idx_r;
  wire        io_we_r, xfer_valid_r, xfer_load_r, busy_r, err_r;
  integer     mismatches, n_checks, i, k;
  localparam [59:0] GRPS = {6'h02, 6'h12, 6'h22, 6'h03, 6'h23, 6'h04,
                            6'h2A, 6'h13, 6'h24, 6'h32};
  cgrf_regfile cgrf_regfile_inst (.clk(clk), .rst_n(rst_n), .op_valid(op_valid),
    .op_code(op_code), .op_size(op_size), .dst_sel(dst_sel), .src_sel(src_sel),
    .use_imm(use_imm), .imm(imm), .bit_num(bit_num), .bit_carry(bit_carry),
    .bit_to_io(bit_to_io), .io_rdata(io_rdata), .multi_first(multi_first),
    .multi_cnt(multi_cnt), .xfer_in(xfer_in), .sp_load(sp_load), .sp_data(sp_data),
    .rd_sel(rd_sel), .rd_size(rd_size), .rd_data_r(rd_data_r), .sp_r(sp_r),
    .result_r(result_r), .io_wdata_r(io_wdata_r), .io_we_r(io_we_r),
    .xfer_data_r(xfer_data_r), .xfer_idx_r(xfer_idx_r), .xfer_valid_r(xfer_valid_r),
    .xfer_load_r(xfer_load_r), .busy_r(busy_r), .err_r(err_r));
  cgrf_core_model cgrf_core_model_inst (.clk(clk), .xfer_valid_r(xfer_valid_r),
    .xfer_load_r(xfer_load_r), .xfer_idx_r(xfer_idx_r), .xfer_in(xfer_in));
  // ********
  // Reference helpers
  // ********
  // Sized view; the select's top bit picks the half or the byte
  function [31:0] view(input [31:0] v, input [1:0] sz, input hi);
    view = (sz == `CGRF_SZ_BYTE) ? (hi ? v[15:8] : v[7:0]) :
           (sz == `CGRF_SZ_WORD) ? (hi ? v[31:16] : v[15:0]) : v;
  endfunction
  // Only the addressed lanes take the new value
  function [31:0] merge(input [31:0] o, input [31:0] n, input [1:0] sz, input hi);
    merge = (sz == `CGRF_SZ_BYTE) ? (hi ? {o[31:16], n[7:0], o[7:0]} : {o[31:8], n[7:0]}) :
            (sz == `CGRF_SZ_WORD) ? (hi ? {n[15:0], o[15:0]} : {o[31:16], n[15:0]}) : n;
  endfunction
  function [31:0] calc(input [3:0] op, input [31:0] a, input [31:0] b, input [1:0] sz);
    case (op)
      `CGRF_OP_MOVE: calc = b;
      `CGRF_OP_AND: calc = a & b;
      `CGRF_OP_OR: calc = a | b;
      `CGRF_OP_XOR: calc = a ^ b;
      `CGRF_OP_NOT: calc = ~a;
      `CGRF_OP_BITSET: calc = a | (32'h1 << bit_num);
      `CGRF_OP_BITCLR: calc = a & ~(32'h1 << bit_num);
      `CGRF_OP_BINV: calc = a ^ (32'h1 << bit_num);
      `CGRF_OP_BSTO: calc = bit_carry ? a | (32'h1 << bit_num) : a & ~(32'h1 << bit_num);
      default: calc = !bit_carry ? a | (32'h1 << bit_num) : a & ~(32'h1 << bit_num);
    endcase
    calc = view(calc, sz, 1'b0);
  endfunction
  task check(input [31:0] got, input [31:0] want);
    begin
      n_checks = n_checks + 1;
      if (got !== want) begin
        mismatches = mismatches + 1;
        $display("wrong value at %0t: got %h want %h", $time, got, want);
      end
    end
  endtask
  task tick;
    begin
      @(posedge clk);
      #1;
    end
  endtask
  // One instruction; the model is updated before the edge that takes it
  task run_op(input [3:0] op, input [1:0] sz, input [3:0] d, input [3:0] s);
    reg [31:0] a;
    begin
      a = bit_to_io ? io_rdata : view(gpr[d[2:0]], sz, d[3]);
      exp_res = calc(op, a, use_imm ? imm : view(gpr[s[2:0]], sz, s[3]), sz);
      if (!bit_to_io) gpr[d[2:0]] = merge(gpr[d[2:0]], exp_res, sz, d[3]);
      {op_code, op_size, dst_sel, src_sel, op_valid} = {op, sz, d, s, 1'b1};
      tick;
      op_valid = 1'b0;
      if (bit_to_io) begin
        check(io_we_r, 1'b1);
        check(io_wdata_r, exp_res);
      end else check(result_r, exp_res);
      {rd_sel, rd_size} = {d, sz};
      tick;
      check(rd_data_r, view(gpr[d[2:0]], sz, d[3]));
    end
  endtask
  task read_all;
    begin
      rd_size = `CGRF_SZ_LONG;
      for (k = 0; k < 8; k = k + 1) begin
        rd_sel = 4'(k);
        tick;
        check(rd_data_r, gpr[k]);
      end
    end
  endtask
  // Multi transfer; a refused move is held up while busy
  task multi(input [3:0] op, input [5:0] g, input ok);
    begin
      {op_code, multi_first, multi_cnt, op_valid} = {op, g, 1'b1};
      tick;
      {op_code, op_size, dst_sel} = {`CGRF_OP_MOVE, `CGRF_SZ_LONG, 4'h3};
      {use_imm, imm} = {1'b1, 32'hFFFFFFFF};
      if (!ok) begin
        op_valid = 1'b0;
        check({err_r, xfer_valid_r}, 2'h2);
      end else begin
        for (k = 0; k < g[2:0]; k = k + 1) begin
          check({xfer_valid_r, xfer_idx_r, xfer_load_r},
                {1'b1, g[5:3] + k[2:0], op == `CGRF_OP_MLOAD});
          if (op == `CGRF_OP_MLOAD) gpr[g[5:3] + k] = 32'hA5C30000 + 32'h00010101 * (g[5:3] + k);
          else check(xfer_data_r, gpr[g[5:3] + k]);
          tick;
        end
        op_valid = 1'b0;
        check(busy_r, 1'b0);
      end
      tick;
    end
  endtask
  task tally_and_finish;
    begin
      if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // ********
  // Stimulus
  // ********
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Run takes well under a thousand cycles
  initial begin
    #50000;
    mismatches = mismatches + 1;
    tally_and_finish;
  end
  initial begin
    k = $urandom(85275);
    {rst_n, op_valid, use_imm, bit_carry, bit_to_io, sp_load, op_code, dst_sel} = 14'h0;
    {src_sel, rd_sel, op_size, rd_size, bit_num, multi_first, multi_cnt} = 21'h0;
    {imm, sp_data, io_rdata} = 72'h0;
    {mismatches, n_checks} = 64'h0;
    for (i = 0; i < 8; i = i + 1) gpr[i] = `CGRF_GPR_RST;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    read_all;
    // Complement at every size on the stack register's upper lane
    for (i = 0; i < 3; i = i + 1) run_op(`CGRF_OP_NOT, 2'(i), 4'hF, 4'h0);
    for (i = 0; i < 80; i = i + 1) begin
      k = $urandom_range(10, 1); // No test-and-set code exists, so none is issued
      {use_imm, imm, bit_num, bit_carry, io_rdata} = 45'({$urandom, $urandom});
      bit_to_io = (k >= 6) && ($urandom_range(3, 0) == 0);
      run_op(4'(k), (k >= 6) ? 2'h0 : 2'($urandom_range(2, 0)),
             4'($urandom), 4'($urandom));
    end
    // No-op leaves the last result and every register alone
    {op_code, op_valid} = {`CGRF_OP_NOP, 1'b1};
    tick;
    op_valid = 1'b0;
    check(result_r, exp_res);
    read_all;
    // Stack load, the second time against a move to the same register
    {bit_to_io, use_imm, op_code, op_size, dst_sel} = {2'h1, `CGRF_OP_MOVE, `CGRF_SZ_LONG, 4'h7};
    for (i = 0; i < 2; i = i + 1) begin
      {sp_data, imm} = {$urandom, $urandom};
      gpr[7] = sp_data;
      {sp_load, op_valid} = {1'b1, i == 1};
      tick;
      {sp_load, op_valid} = 2'h0;
      check(sp_r, gpr[7]);
    end
    for (i = 0; i < 20; i = i + 1)
      multi(i < 10 ? `CGRF_OP_MSTORE : `CGRF_OP_MLOAD,
            GRPS[59 - 6 * (i % 10) -: 6], (i % 10) < 6);
    read_all;
    tally_and_finish;
  end
endmodule
